/* File: hdl/mces_top.sv */
// machine-check scope top: error intake, exception control, AXI4-Lite registers
`timescale 1ns/1ns
module mces_top
	import mces_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	// error sources
	input  wire logic                 errValid,
	input  wire logic [BANK_BITS-1:0] errBank,
	input  wire logic                 errCorrected,
	input  wire logic                 errDeferred,
	input  wire logic                 errCtxCorrupt,
	input  wire logic                 errThrCorrupt,
	input  wire logic                 errRestartOk,
	input  wire logic                 errIpRelated,
	input  wire logic                 errAddrValid,
	input  wire logic                 errMiscValid,
	input  wire logic [31:0]          errAddr,
	input  wire logic [31:0]          errMisc,
	// exception delivery
	output logic                      checkException,
	output logic                      shutdown,
	output logic                      deferredIrq,
	output logic                      thresholdIrq,
	output mces_scope_t               errScope,
	// AXI4-Lite slave
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic        rstMeta;
	logic        rst;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstMeta <= 1'b0;
			rst     <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rst     <= rstMeta;
		end
	end

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [31:0]          ctrl;
	logic [15:0]          threshold;
	logic                 restartValid;
	logic                 errIpValid;
	logic                 inProgress;
	mces_core_t           coreState;
	mces_core_t           next_coreState;
	logic [31:0]          classWord;
	mces_scope_t          classScope;
	logic [31:0]          bankStatus [NUM_BANKS];
	logic [31:0]          bankAddr   [NUM_BANKS];
	logic [31:0]          bankMisc   [NUM_BANKS];
	logic [15:0]          bankCount  [NUM_BANKS];
	logic                 raiseCheck;
	logic                 wrGo;
	logic [7:0]           wrAddrQ;
	logic [31:0]          wrDataQ;
	logic [3:0]           wrStrbQ;
	logic                 awHeld;
	logic                 wHeld;
	logic [31:0]          wrMerged;
	logic [31:0]          wrBase;
	logic                 wrHit;
	logic                 rdHit;
	logic [31:0]          rdWord;
	logic [BANK_BITS-1:0] wrBankSel;
	logic [BANK_BITS-1:0] rdBankSel;
	logic                 wrInBank;
	logic                 rdInBank;

	// ----------------------------------------------------------------
	// classification and banks
	// ----------------------------------------------------------------
	mces_classify u_classify (
		.corrected  (errCorrected),
		.deferred   (errDeferred),
		.ctxCorrupt (errCtxCorrupt),
		.thrCorrupt (errThrCorrupt),
		.recovery   (ctrl[CT_RECOV]),
		.addrValid  (errAddrValid),
		.miscValid  (errMiscValid),
		.overwrite  (bankStatus[errBank][ST_VALID]),
		.statusWord (classWord),
		.scope      (classScope)
	);

	assign wrInBank  = wrAddrQ >= OFF_BANK0;
	assign rdInBank  = s_axi_araddr >= OFF_BANK0;
	assign wrBankSel = BANK_BITS'((wrAddrQ - OFF_BANK0) >> 4);
	assign rdBankSel = BANK_BITS'((s_axi_araddr - OFF_BANK0) >> 4);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
			logic sel;
			assign sel = wrGo && wrHit && wrInBank && wrBankSel == BANK_BITS'(gi);
			mces_bank u_bank (
				.clk       (clk),
				.rst       (rst),
				.logEn     (errValid && errBank == BANK_BITS'(gi)),
				.logStatus (classWord),
				.logAddr   (errAddr),
				.logMisc   (errMisc),
				.wrStatus  (sel && wrAddrQ[3:0] == BW_STATUS),
				.wrAddr    (sel && wrAddrQ[3:0] == BW_ADDR),
				.wrMisc    (sel && wrAddrQ[3:0] == BW_MISC),
				.wrCount   (sel && wrAddrQ[3:0] == BW_COUNT),
				.wrData    (wrMerged),
				.status    (bankStatus[gi]),
				.addr      (bankAddr[gi]),
				.misc      (bankMisc[gi]),
				.count     (bankCount[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// exception decision
	// ----------------------------------------------------------------
	// corrected and deferred errors never trap
	assign raiseCheck = errValid && classWord[ST_UNCORR];

	always_comb begin
		next_coreState = coreState;
		case (coreState)
			CS_RUN, CS_HANDLER: begin
				if (raiseCheck && (!ctrl[CT_EXCEN] || inProgress))
					next_coreState = CS_SHUTDOWN;
				else if (raiseCheck)
					next_coreState = CS_HANDLER;
				else if (coreState == CS_HANDLER && !inProgress)
					next_coreState = CS_RUN;
			end
			CS_SHUTDOWN: next_coreState = CS_SHUTDOWN;  // only reset leaves
			default:     next_coreState = CS_SHUTDOWN;
		endcase
	end

	always_ff @(posedge clk or negedge rst) begin
		if (!rst)
			coreState <= CS_RUN;
		else
			coreState <= next_coreState;
	end

	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			checkException <= 1'b0;
			shutdown       <= 1'b0;
			deferredIrq    <= 1'b0;
			thresholdIrq   <= 1'b0;
			errScope       <= SC_CORRECTED;
		end else begin
			checkException <= coreState != CS_SHUTDOWN && raiseCheck
				&& ctrl[CT_EXCEN] && !inProgress;
			shutdown       <= next_coreState == CS_SHUTDOWN;
			deferredIrq    <= errValid && classWord[ST_DEFER] && ctrl[CT_DEFIEN];
			thresholdIrq   <= errValid && !classWord[ST_UNCORR] && !classWord[ST_DEFER]
				&& ctrl[CT_THRIEN] && bankCount[errBank] + 16'h0001 == threshold;
			if (errValid)
				errScope <= classScope;
		end
	end

	// global status: hardware set wins over software clear
	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			restartValid <= 1'b0;
			errIpValid   <= 1'b0;
			inProgress   <= 1'b0;
		end else if (raiseCheck && ctrl[CT_EXCEN] && !inProgress) begin
			restartValid <= errRestartOk && !errCtxCorrupt;
			errIpValid   <= errIpRelated;
			inProgress   <= 1'b1;
		end else if (wrGo && wrAddrQ == OFF_GSTAT) begin
			restartValid <= wrMerged[GS_RESTART];
			errIpValid   <= wrMerged[GS_ERRIP];
			inProgress   <= wrMerged[GS_INPROG];
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write
	// ----------------------------------------------------------------
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign wrGo          = awHeld && wHeld;
	assign wrHit         = wrAddrQ[1:0] == 2'h0 && (wrAddrQ < OFF_BANK0
		|| (wrAddrQ - OFF_BANK0) < 8'(NUM_BANKS * 16));

	always_comb begin
		wrBase   = 32'h0000_0000;
		wrMerged = 32'h0000_0000;
		if (wrAddrQ == OFF_GSTAT)
			wrBase = {29'h0000_0000, inProgress, errIpValid, restartValid};
		else if (wrAddrQ == OFF_CTRL)
			wrBase = ctrl;
		else if (wrAddrQ == OFF_THRESH)
			wrBase = {16'h0000, threshold};
		else if (wrInBank) begin
			case (wrAddrQ[3:0])
				BW_STATUS: wrBase = bankStatus[wrBankSel];
				BW_ADDR:   wrBase = bankAddr[wrBankSel];
				BW_MISC:   wrBase = bankMisc[wrBankSel];
				BW_COUNT:  wrBase = {16'h0000, bankCount[wrBankSel]};
				default:   wrBase = 32'h0000_0000;
			endcase
		end
		// lanes without a strobe keep the register's current bytes
		for (int b = 0; b < 4; b++)
			wrMerged[b*8 +: 8] = wrStrbQ[b] ? wrDataQ[b*8 +: 8] : wrBase[b*8 +: 8];
	end

	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			awHeld  <= 1'b0;
			wHeld   <= 1'b0;
			wrAddrQ <= 8'h00;
			wrDataQ <= 32'h0000_0000;
			wrStrbQ <= 4'h0;
		end else if (wrGo) begin
			awHeld <= 1'b0;
			wHeld  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld  <= 1'b1;
				wrAddrQ <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld   <= 1'b1;
				wrDataQ <= s_axi_wdata;
				wrStrbQ <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			ctrl      <= CTRL_RST;
			threshold <= THRESH_RST;
		end else if (wrGo && wrAddrQ == OFF_CTRL) begin
			ctrl <= {27'h0000_0000, wrMerged[4:0]};
		end else if (wrGo && wrAddrQ == OFF_THRESH) begin
			threshold <= wrMerged[15:0];
		end
	end

	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wrGo) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign rdHit = s_axi_araddr[1:0] == 2'h0 && (s_axi_araddr < OFF_BANK0
		|| (s_axi_araddr - OFF_BANK0) < 8'(NUM_BANKS * 16));

	always_comb begin
		rdWord = 32'h0000_0000;
		if (s_axi_araddr == OFF_GSTAT)
			rdWord = {29'h0000_0000, inProgress, errIpValid, restartValid};
		else if (s_axi_araddr == OFF_GCAP)
			rdWord = 32'(NUM_BANKS);
		else if (s_axi_araddr == OFF_CTRL)
			rdWord = ctrl;
		else if (s_axi_araddr == OFF_THRESH)
			rdWord = {16'h0000, threshold};
		else if (rdInBank && rdHit) begin
			case (s_axi_araddr[3:0])
				BW_STATUS: rdWord = bankStatus[rdBankSel];
				BW_ADDR:   rdWord = bankAddr[rdBankSel];
				BW_MISC:   rdWord = bankMisc[rdBankSel];
				BW_COUNT:  rdWord = {16'h0000, bankCount[rdBankSel]};
				default:   rdWord = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdHit ? rdWord : 32'h0000_0000;
			s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_exc_on_uncorr: assert property (@(posedge clk) disable iff (!rst)
		raiseCheck && ctrl[CT_EXCEN] && !inProgress && coreState != CS_SHUTDOWN
		|=> checkException) else $error("uncorrected error did not trap");
	chk_no_exc_corr: assert property (@(posedge clk) disable iff (!rst)
		errValid && errCorrected |=> !checkException)
		else $error("corrected error trapped");
	chk_nested_shut: assert property (@(posedge clk) disable iff (!rst)
		raiseCheck && inProgress |=> shutdown [*3])
		else $error("nested check did not shut down");
	chk_disabled_shut: assert property (@(posedge clk) disable iff (!rst)
		raiseCheck && !ctrl[CT_EXCEN] |=> shutdown)
		else $error("check with enable clear did not shut down");
	chk_fatal_flags: assert property (@(posedge clk) disable iff (!rst)
		errValid && !errCorrected && !errDeferred && errCtxCorrupt
		|-> classWord[ST_CTXC] && classWord[ST_UNCORR])
		else $error("fatal flags wrong");
	chk_corr_flags: assert property (@(posedge clk) disable iff (!rst)
		errValid && errCorrected |-> classWord[ST_THRC +: 2] == 2'h0
		&& !classWord[ST_UNCORR] && !classWord[ST_DEFER])
		else $error("corrected flags wrong");
	chk_inprog_set: assert property (@(posedge clk) disable iff (!rst)
		checkException |-> inProgress && $past(errValid))
		else $error("in-progress not set with exception");
	chk_defer_irq: assert property (@(posedge clk) disable iff (!rst)
		errValid && errDeferred && !errCorrected && !errCtxCorrupt && ctrl[CT_DEFIEN]
		|=> deferredIrq) else $error("deferred interrupt missing");
endmodule

/* File: hdl/mces_pkg.sv */
// package of constants and types for the machine-check error scope block
// What this block does
// - uncorrected error with exception enable on raises machine-check exception
// - deferred error or corrected-error threshold may raise an interrupt
// - context-corrupted error logs context_corrupt and uncorrected both 1: fatal
// - recoverable error logs context 0, thread 0, uncorrected 1
// - containable error logs context 0, thread 1, uncorrected 1
// - deferred latent error logs deferred 1, other three flags 0
// - self-corrected error logs all four classification flags 0
// - a self-corrected error never raises a machine-check exception
// - exception while check_in_progress is set enters shutdown
// - restart_ip_valid set only when restart at saved pointer is reliable
// - error_ip_valid set only when saved pointer relates to the error
// - a bank status with entry_valid clear holds no meaningful error
// - overflow set when logged error information was overwritten
// - uncorrected_flag set only when the logged error was not corrected
// - with recovery supported, thread flag follows thread context corruption
// - address_info_valid set only when address register belongs to error
// - software clears entry_valid after logging, freeing bank for next error
// - capability count field gives number of implemented banks
// - machine-check condition with exception enable clear enters shutdown
package mces_pkg;
	localparam int          NUM_BANKS   = 4;
	localparam int          BANK_BITS   = 2;
	// register byte offsets
	localparam logic [7:0]  OFF_GSTAT   = 8'h00;
	localparam logic [7:0]  OFF_GCAP    = 8'h04;
	localparam logic [7:0]  OFF_CTRL    = 8'h08;
	localparam logic [7:0]  OFF_THRESH  = 8'h0C;
	localparam logic [7:0]  OFF_BANK0   = 8'h10;
	localparam logic [7:0]  BANK_STRIDE = 8'h10;
	// bank word offsets inside a bank
	localparam logic [3:0]  BW_STATUS   = 4'h0;
	localparam logic [3:0]  BW_ADDR     = 4'h4;
	localparam logic [3:0]  BW_MISC     = 4'h8;
	localparam logic [3:0]  BW_COUNT    = 4'hC;
	// bank status bit positions
	localparam int          ST_VALID    = 31;
	localparam int          ST_OVER     = 30;
	localparam int          ST_UNCORR   = 29;
	localparam int          ST_MISC_INFO_VALID    = 27;
	localparam int          ST_ADDRESS_INFO_VALID    = 26;
	localparam int          ST_CTXC     = 25;
	localparam int          ST_THRC     = 24;
	localparam int          ST_DEFER    = 23;
	// global status bit positions
	localparam int          GS_RESTART  = 0;
	localparam int          GS_ERRIP    = 1;
	localparam int          GS_INPROG   = 2;
	// control bit positions
	localparam int          CT_EXCEN    = 0;
	localparam int          CT_DEFIEN   = 1;
	localparam int          CT_THRIEN   = 2;
	localparam int          CT_RECOV    = 3;
	localparam int          CT_OVRECOV  = 4;
	// reset values and AXI response codes
	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [15:0] THRESH_RST  = 16'hFFFF;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		SC_CORRECTED = 5'h01,
		SC_DEFERRED  = 5'h02,
		SC_RECOVER   = 5'h04,
		SC_CONTAIN   = 5'h08,
		SC_FATAL     = 5'h10
	} mces_scope_t;

	typedef enum logic [2:0] {
		CS_RUN      = 3'h1,
		CS_HANDLER  = 3'h2,
		CS_SHUTDOWN = 3'h4
	} mces_core_t;
endpackage

/* File: hdl/mces_classify.sv */
// error classifier: source report to bank status flag word
`timescale 1ns/1ns
module mces_classify
	import mces_pkg::*;
(
	input  wire logic        corrected,
	input  wire logic        deferred,
	input  wire logic        ctxCorrupt,
	input  wire logic        thrCorrupt,
	input  wire logic        recovery,
	input  wire logic        addrValid,
	input  wire logic        miscValid,
	input  wire logic        overwrite,
	output logic [31:0]      statusWord,
	output mces_scope_t      scope
);
	logic uncorr;
	logic thr;
	logic def;

	always_comb begin
		uncorr = !corrected && !deferred;
		thr    = uncorr && !ctxCorrupt && recovery && thrCorrupt;
		def    = deferred && !corrected;
		statusWord = 32'h0000_0000;
		// all flags built together so one write lands them at once
		statusWord[ST_VALID]  = 1'b1;
		statusWord[ST_OVER]   = overwrite;
		statusWord[ST_UNCORR] = uncorr;
		statusWord[ST_CTXC]   = uncorr && ctxCorrupt;
		statusWord[ST_THRC]   = thr;
		statusWord[ST_DEFER]  = def && !ctxCorrupt;
		statusWord[ST_ADDRESS_INFO_VALID]  = addrValid;
		statusWord[ST_MISC_INFO_VALID]  = miscValid;
		if (uncorr && ctxCorrupt)
			scope = SC_FATAL;
		else if (uncorr && thr)
			scope = SC_CONTAIN;
		else if (uncorr)
			scope = SC_RECOVER;
		else if (statusWord[ST_DEFER])
			scope = SC_DEFERRED;
		else
			scope = SC_CORRECTED;
	end
endmodule

/* File: hdl/mces_bank.sv */
// one error-reporting bank: status, address, misc and corrected count
`timescale 1ns/1ns
module mces_bank
	import mces_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        logEn,
	input  wire logic [31:0] logStatus,
	input  wire logic [31:0] logAddr,
	input  wire logic [31:0] logMisc,
	input  wire logic        wrStatus,
	input  wire logic        wrAddr,
	input  wire logic        wrMisc,
	input  wire logic        wrCount,
	input  wire logic [31:0] wrData,
	output logic [31:0]      status,
	output logic [31:0]      addr,
	output logic [31:0]      misc,
	output logic [15:0]      count
);
	logic isCorrected;

	assign isCorrected = logEn && !logStatus[ST_UNCORR] && !logStatus[ST_DEFER];

	// a new log wins over a software clear in the same cycle
	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			status <= 32'h0000_0000;
		end else if (logEn) begin
			status <= logStatus | {1'b0, status[ST_VALID], 30'h0000_0000};
		end else if (wrStatus) begin
			status <= wrData;
		end
	end

	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			addr <= 32'h0000_0000;
			misc <= 32'h0000_0000;
		end else begin
			if (logEn)
				addr <= logAddr;
			else if (wrAddr)
				addr <= wrData;
			if (logEn)
				misc <= logMisc;
			else if (wrMisc)
				misc <= wrData;
		end
	end

	// saturating corrected-error counter, no rollover
	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			count <= 16'h0000;
		end else if (isCorrected && count != 16'hFFFF) begin
			count <= count + 16'h0001;
		end else if (wrCount && !isCorrected) begin
			count <= wrData[15:0];
		end
	end
endmodule

/* File: testbench/mces_src_model.sv */
// core-side error source model feeding the scope block
`timescale 1ns/1ns
module mces_src_model
	import mces_pkg::*;
(
	input  wire logic            clk,
	output logic                 errValid,
	output logic [BANK_BITS-1:0] errBank,
	output logic [7:0]           errFlags,
	output logic [31:0]          errAddr,
	output logic [31:0]          errMisc
);
	logic [31:0] heldAddr;
	logic [7:0]  heldFlags;
	initial begin
		errValid  = 1'b0;
		errBank   = '0;
		heldAddr  = 32'h0;
		heldFlags = 8'h00;
	end
	// idle lines carry the inverse of the last report, so stale data never looks fresh
	assign errAddr  = errValid ? heldAddr : ~heldAddr;
	assign errFlags = errValid ? heldFlags : ~heldFlags;
	assign errMisc  = ~errAddr;
	task automatic report(input logic [BANK_BITS-1:0] b, input logic [7:0] f,
			input logic [31:0] a);
		@(posedge clk);
		errValid  <= 1'b1;
		errBank   <= b;
		heldFlags <= f;
		heldAddr  <= a;
		@(posedge clk);
		errValid  <= 1'b0;
	endtask
endmodule

/* File: testbench/tb_machine_check_error_scope.sv */
// self-checking bench for the machine-check scope block
`timescale 1ns/1ns
module tb_machine_check_error_scope
	import mces_pkg::*;
;
	logic clk, rstn, errValid, checkException, shutdown, deferredIrq, thresholdIrq;
	logic [1:0] errBank, bresp, rresp;
	logic [7:0] f, awaddr, araddr;
	logic [31:0] errAddr, errMisc, wdata, rdata;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	mces_scope_t errScope;
	int errTotal, samplesChecked, excCnt, defCnt, thrCnt;
	mces_src_model u_mces_src_model (.clk(clk), .errValid(errValid), .errBank(errBank),
		.errFlags(f), .errAddr(errAddr), .errMisc(errMisc));
	mces_top u_mces_top (.clk(clk), .rstn(rstn), .errValid(errValid), .errBank(errBank),
		.errCorrected(f[0]), .errDeferred(f[1]), .errCtxCorrupt(f[2]),
		.errThrCorrupt(f[3]), .errAddrValid(f[4]), .errMiscValid(f[5]),
		.errRestartOk(f[6]), .errIpRelated(f[7]), .errAddr(errAddr), .errMisc(errMisc),
		.checkException(checkException), .shutdown(shutdown), .deferredIrq(deferredIrq),
		.thresholdIrq(thresholdIrq), .errScope(errScope), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// pulses are counted at the falling edge, away from the edge that launches them
	always @(negedge clk) begin
		excCnt <= excCnt + int'(checkException);
		defCnt <= defCnt + int'(deferredIrq);
		thrCnt <= thrCnt + int'(thresholdIrq);
	end
	task automatic completeRun();
		$display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samplesChecked++;
		if (got !== exp) begin
			errTotal++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		awvalid <= w;
		wvalid  <= w;
		bready  <= w;
		arvalid <= !w;
		rready  <= !w;
		awaddr  <= a;
		araddr  <= a;
		wdata   <= d;
		while (n < 50) begin
			@(posedge clk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (arready)
				arvalid <= 1'b0;
			if ((bvalid && bready) || (rvalid && rready)) begin
				q = rdata;
				r = w ? bresp : rresp;
				bready <= 1'b0;
				rready <= 1'b0;
				n = 99;
			end
		end
		if (n != 99) begin
			chk(32'h0, 32'h1, "bus wait");
			completeRun();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic [1:0] r;
		bus(1'b1, a, d, q, r);
		chk(32'(r), 32'(RESP_OKAY), "write resp");
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic [1:0] r;
		bus(1'b0, a, 32'h0, q, r);
	endtask
	task automatic doReset();
		rstn <= 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// report an error, then judge exception count, scope, status flags and address
	task automatic logErr(input logic [1:0] b, input logic [7:0] fl, input logic ov,
			input int ex, input mces_scope_t sc);
		logic [31:0] q, e;
		int e0;
		e0 = excCnt;
		e = {1'b1, ov, ~(fl[0] | fl[1]), 1'b0, fl[5], fl[4], fl[2], fl[3], fl[1], 23'h0};
		u_mces_src_model.report(b, fl, {24'hA5C3E1, fl});
		repeat (4) @(posedge clk);
		chk(32'(excCnt - e0), 32'(ex), "exceptions");
		chk(32'(errScope), 32'(sc), "scope");
		rd(8'(OFF_BANK0 + BANK_STRIDE * b), q);
		chk(q & 32'hEF80_0000, e, "status");
		rd(8'(OFF_BANK0 + BANK_STRIDE * b + BW_ADDR), q);
		if (fl[4])
			chk(q, {24'hA5C3E1, fl}, "address");
	endtask
	task automatic tRegs();
		logic [31:0] q;
		logic [1:0] r;
		chk(32'(errScope), 32'(SC_CORRECTED), "scope reset");
		rd(OFF_CTRL, q);
		chk(q, CTRL_RST, "ctrl reset");
		rd(OFF_THRESH, q);
		chk(q, {16'h0, THRESH_RST}, "threshold reset");
		rd(OFF_GCAP, q);
		chk({24'h0, q[7:0]}, 32'(NUM_BANKS), "bank count");
		bus(1'b0, 8'h50, 32'h0, q, r);
		chk(32'(r), 32'(RESP_SLVERR), "unmapped resp");
		bus(1'b1, 8'h50, 32'hFFFF_FFFF, q, r);
		chk(32'(r), 32'(RESP_SLVERR), "unmapped write resp");
		rd(OFF_BANK0, q);
		chk(q, 32'h0, "unmapped write kept out");
	endtask
	task automatic tFlow();
		logic [31:0] q;
		logic [7:0] tab [3] = '{8'hC0, 8'h48, 8'h84};
		mces_scope_t sct [3] = '{SC_RECOVER, SC_CONTAIN, SC_FATAL};
		wr(OFF_CTRL, 32'h0000_001F);
		rd(OFF_CTRL, q);
		chk(q, 32'h0000_001F, "ctrl readback");
		wr(OFF_THRESH, 32'h0000_0001);
		logErr(2'h0, 8'h11, 1'b0, 0, SC_CORRECTED);
		chk(32'(thrCnt), 32'h1, "threshold irq");
		logErr(2'h1, 8'h22, 1'b0, 0, SC_DEFERRED);
		chk(32'(defCnt), 32'h1, "deferred irq");
		wr(8'(OFF_BANK0 + BANK_STRIDE), 32'h0);
		rd(8'(OFF_BANK0 + BANK_STRIDE), q);
		chk(32'(q[ST_VALID]), 32'h0, "valid cleared");
		for (int i = 0; i < 3; i++) begin
			logErr(2'h2, tab[i], 1'b0, 1, sct[i]);
			rd(OFF_GSTAT, q);
			chk({29'h0, q[2:0]}, {29'h0, 1'b1, tab[i][7:6]}, "global");
			wr(OFF_GSTAT, 32'h0);
			wr(8'(OFF_BANK0 + 2 * BANK_STRIDE), 32'h0);
		end
		logErr(2'h3, 8'h01, 1'b0, 0, SC_CORRECTED);
		logErr(2'h3, 8'h01, 1'b1, 0, SC_CORRECTED);
		logErr(2'h2, 8'h00, 1'b0, 1, SC_RECOVER);
		chk(32'(shutdown), 32'h0, "no shutdown");
		u_mces_src_model.report(2'h1, 8'h08, 32'h0);
		repeat (4) @(posedge clk);
		chk(32'(shutdown), 32'h1, "nested shutdown");
	endtask
	task automatic tDisabled();
		int e0;
		doReset();
		e0 = excCnt;
		u_mces_src_model.report(2'h0, 8'h00, 32'h0);
		repeat (4) @(posedge clk);
		chk(32'(shutdown), 32'h1, "disabled shutdown");
		chk(32'(excCnt - e0), 32'h0, "no exception");
	endtask
	initial begin
		{rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		{errTotal, samplesChecked, excCnt, defCnt, thrCnt} = '0;
		doReset();
		tRegs();
		tFlow();
		tDisabled();
		completeRun();
	end
	initial begin
		repeat (20000) @(posedge clk);
		errTotal++;
		completeRun();
	end
endmodule
